// ---- verilog/isa_top.v ----
// two-wire bus slave: address matching, transmit with clock stretch, receive
// assumes open-drain bus lines with external pull-ups and a bus master peer
`include "isa_map.vh"

module isa_top (
    input wire core_clk,
    input wire rst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire scl_in,
    output wire scl_out,
    output reg scl_oe,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    output reg slave_event_flag
);

// ------------------------------------------------------------------
// states, one-hot; byte kinds binary
// ------------------------------------------------------------------
localparam S_IDLE = 6'h01;
localparam S_RECV = 6'h02;
localparam S_ACK = 6'h04;
localparam S_STRETCH = 6'h08;
localparam S_SEND = 6'h10;
localparam S_MACK = 6'h20;

localparam K_ADDR1 = 2'h0;
localparam K_ADDR2 = 2'h1;
localparam K_DATA = 2'h2;

// open-drain: only ever pull low
assign scl_out = 1'b0;
assign sda_out = 1'b0;

// ------------------------------------------------------------------
// bus line synchronisers
// ------------------------------------------------------------------
wire scl_lvl;
wire scl_rise;
wire scl_fall;
wire sda_lvl;
wire sda_rise;
wire sda_fall;

isa_sync u_scl (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(scl_in),
    .level(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
);

isa_sync u_sda (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(sda_in),
    .level(sda_lvl),
    .rise(sda_rise),
    .fall(sda_fall)
);

// start and stop: data moves while clock stays high
wire start_det = sda_fall & scl_lvl & ~scl_rise & ~scl_fall;
wire stop_det = sda_rise & scl_lvl & ~scl_rise & ~scl_fall;

// ------------------------------------------------------------------
// register bus front end
// ------------------------------------------------------------------
wire wr_en;
wire [7:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire rd_en;
wire [7:0] rd_addr;
reg [31:0] rd_data;

function addr_hit;
    input [7:0] a;
    begin
        addr_hit = (a == `ISA_OFF_CTRL) || (a == `ISA_OFF_STAT) ||
                   (a == `ISA_OFF_RXBUF) || (a == `ISA_OFF_TXBYTE) ||
                   (a == `ISA_OFF_OWNADDR) || (a == `ISA_OFF_BAUD);
    end
endfunction

// merge low two byte lanes; registers here are at most 16 bits
function [15:0] lane_merge;
    input [15:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
        lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
endfunction

isa_axil #(.AW(8)) u_axil (
    .core_clk(core_clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(~addr_hit(wr_addr)),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(~addr_hit(rd_addr))
);

wire wr_ctrl = wr_en && (wr_addr == `ISA_OFF_CTRL);
wire wr_stat = wr_en && (wr_addr == `ISA_OFF_STAT);
wire wr_tx = wr_en && (wr_addr == `ISA_OFF_TXBYTE) && wr_strb[0];
wire wr_own = wr_en && (wr_addr == `ISA_OFF_OWNADDR);
wire wr_baud = wr_en && (wr_addr == `ISA_OFF_BAUD);
wire rd_rxbuf = rd_en && (rd_addr == `ISA_OFF_RXBUF);

// ------------------------------------------------------------------
// software-visible state
// ------------------------------------------------------------------
reg [15:0] ctrl_r;
reg [9:0] stat_hi_r;
reg [9:0] own_addr_r;
reg [8:0] baud_r;
reg [7:0] rx_buf_r;
reg [7:0] tx_byte_r;
reg rbf_r;
reg tbf_r;
reg dir_r;
reg full_ten_bit_match_flag_r;

wire en = ctrl_r[`ISA_CTRL_EN];
wire ten_bit_address_select = ctrl_r[`ISA_CTRL_A10];
wire ov = stat_hi_r[`ISA_STAT_OV-`ISA_STAT_RO_W];
// merged write words; narrow fields keep their own upper bits
wire [15:0] stat_merge = lane_merge({stat_hi_r, 6'h00}, wr_data, wr_strb);
wire [15:0] own_merge = lane_merge({6'h00, own_addr_r}, wr_data, wr_strb);
wire [15:0] baud_merge = lane_merge({7'h00, baud_r}, wr_data, wr_strb);

// ------------------------------------------------------------------
// protocol engine state
// ------------------------------------------------------------------
reg [5:0] state_r;
reg [1:0] kind_r;
reg [3:0] cnt_r;
reg [7:0] sh_r;
reg ack_r;
reg ev_pend_r;
reg go_tx_r;
reg go_idle_r;
reg mack_r;

// hardware events feeding software flags
reg load_rx;
reg set_ov;
reg clr_rel;

// ------------------------------------------------------------------
// register read mux
// ------------------------------------------------------------------
always @* begin
    rd_data = 32'h00000000;
    case (rd_addr)
        `ISA_OFF_CTRL: rd_data[15:0] = ctrl_r;
        `ISA_OFF_STAT: rd_data[15:0] = {stat_hi_r, 1'b0, state_r != S_IDLE,
                                        full_ten_bit_match_flag_r, dir_r, tbf_r, rbf_r};
        `ISA_OFF_RXBUF: rd_data[7:0] = rx_buf_r;
        `ISA_OFF_TXBYTE: rd_data[7:0] = tx_byte_r;
        `ISA_OFF_OWNADDR: rd_data[9:0] = own_addr_r;
        `ISA_OFF_BAUD: rd_data[8:0] = baud_r;
        default: rd_data = 32'h00000000;
    endcase
end

// ------------------------------------------------------------------
// software registers and flags; hardware set beats software clear
// ------------------------------------------------------------------
always @(posedge core_clk) begin
    if (rst) begin
        ctrl_r <= `ISA_CTRL_RST;
        stat_hi_r <= `ISA_STAT_RST;
        own_addr_r <= `ISA_OWN_RST;
        baud_r <= `ISA_BAUD_RST;
        tx_byte_r <= 8'h00;
        tbf_r <= 1'b0;
        rbf_r <= 1'b0;
        rx_buf_r <= 8'h00;
    end else begin
        if (wr_ctrl)
            ctrl_r <= lane_merge(ctrl_r, wr_data, wr_strb);
        else if (clr_rel)
            ctrl_r[`ISA_CTRL_REL] <= 1'b0;
        // only bits above the read-only field take writes
        if (wr_stat)
            stat_hi_r <= stat_merge[15:6];
        if (set_ov)
            stat_hi_r[`ISA_STAT_OV-`ISA_STAT_RO_W] <= 1'b1;
        if (wr_own)
            own_addr_r <= own_merge[9:0];
        if (wr_baud)
            baud_r <= baud_merge[8:0];
        // single transmit register, no staging behind it
        if (wr_tx) begin
            tx_byte_r <= wr_data[7:0];
            tbf_r <= 1'b1;
        end else if (state_r == S_STRETCH && ctrl_r[`ISA_CTRL_REL] && !clr_rel) begin
            tbf_r <= 1'b0;
        end
        if (load_rx) begin
            rx_buf_r <= sh_r;
            rbf_r <= 1'b1;
        end else if (rd_rxbuf) begin
            rbf_r <= 1'b0;
        end
    end
end

// ------------------------------------------------------------------
// address compare helpers
// ------------------------------------------------------------------
// header byte: 11110 then own bits 9:8
wire hdr_hit = (sh_r[7:3] == `ISA_HDR10) && (sh_r[2:1] == own_addr_r[9:8]);
// 0x00-0x07 and 0x78-0x7f never match as ordinary addresses
wire norm_ok = (sh_r[7:1] >= 7'h08) && (sh_r[7:1] <= 7'h77);
wire hit7 = norm_ok && (sh_r[7:1] == own_addr_r[6:0]);

// ------------------------------------------------------------------
// bus engine
// ------------------------------------------------------------------
always @(posedge core_clk) begin
    load_rx <= 1'b0;
    set_ov <= 1'b0;
    clr_rel <= 1'b0;
    slave_event_flag <= 1'b0;
    if (rst) begin
        state_r <= S_IDLE;
        kind_r <= K_ADDR1;
        cnt_r <= 4'h0;
        sh_r <= 8'h00;
        ack_r <= 1'b0;
        ev_pend_r <= 1'b0;
        go_tx_r <= 1'b0;
        go_idle_r <= 1'b0;
        mack_r <= 1'b0;
        dir_r <= 1'b0;
        full_ten_bit_match_flag_r <= 1'b0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        load_rx <= 1'b0;
        set_ov <= 1'b0;
        clr_rel <= 1'b0;
        slave_event_flag <= 1'b0;
    end else if (!en || stop_det) begin
        state_r <= S_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
    end else if (start_det) begin
        // start or repeated start: begin an address byte
        state_r <= S_RECV;
        kind_r <= K_ADDR1;
        cnt_r <= 4'h0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
    end else begin
        case (state_r)
            S_IDLE: begin
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
            end
            S_RECV: begin
                if (scl_rise && cnt_r != `ISA_BYTE_BITS) begin
                    sh_r <= {sh_r[6:0], sda_lvl};
                    cnt_r <= cnt_r + 4'h1;
                end else if (scl_fall && cnt_r == `ISA_BYTE_BITS) begin
                    state_r <= S_ACK;
                    ev_pend_r <= 1'b0;
                    go_tx_r <= 1'b0;
                    go_idle_r <= 1'b0;
                    ack_r <= 1'b0;
                    case (kind_r)
                        K_ADDR1: begin
                            if (!ten_bit_address_select) begin
                                // seven-bit compare leaves buffer alone
                                ack_r <= hit7;
                                ev_pend_r <= hit7;
                                go_tx_r <= sh_r[0];
                                go_idle_r <= ~hit7;
                                dir_r <= hit7 ? sh_r[0] : dir_r;
                            end else if (hdr_hit && !sh_r[0]) begin
                                ack_r <= 1'b1;
                                ev_pend_r <= 1'b1;
                                full_ten_bit_match_flag_r <= 1'b0;
                                dir_r <= 1'b0;
                                kind_r <= K_ADDR2;
                            end else if (hdr_hit && full_ten_bit_match_flag_r) begin
                                // restart read after full match
                                ack_r <= 1'b1;
                                ev_pend_r <= 1'b1;
                                dir_r <= 1'b1;
                                go_tx_r <= 1'b1;
                            end else begin
                                full_ten_bit_match_flag_r <= 1'b0;
                                go_idle_r <= 1'b1;
                            end
                        end
                        K_ADDR2: begin
                            ack_r <= (sh_r == own_addr_r[7:0]);
                            ev_pend_r <= (sh_r == own_addr_r[7:0]);
                            full_ten_bit_match_flag_r <= (sh_r == own_addr_r[7:0]);
                            go_idle_r <= (sh_r != own_addr_r[7:0]);
                            kind_r <= K_DATA;
                        end
                        default: begin
                            // data byte: full buffer drops it, overflow refuses it
                            ev_pend_r <= 1'b1;
                            ack_r <= ~rbf_r & ~ov;
                            load_rx <= ~rbf_r;
                            set_ov <= rbf_r;
                        end
                    endcase
                    if (kind_r == K_ADDR1 && !ten_bit_address_select)
                        kind_r <= K_DATA;
                end
            end
            S_ACK: begin
                // pull data low through the ninth clock when acknowledging
                sda_oe <= ack_r;
                if (go_idle_r && !ack_r) begin
                    state_r <= S_IDLE;
                    sda_oe <= 1'b0;
                end else if (scl_fall) begin
                    sda_oe <= 1'b0;
                    slave_event_flag <= ev_pend_r;
                    cnt_r <= 4'h0;
                    if (go_idle_r) begin
                        state_r <= S_IDLE;
                    end else if (go_tx_r) begin
                        state_r <= S_STRETCH;
                        scl_oe <= 1'b1;
                        clr_rel <= 1'b1;
                    end else begin
                        state_r <= S_RECV;
                    end
                end
            end
            S_STRETCH: begin
                // hold clock low until software releases it
                scl_oe <= 1'b1;
                if (ctrl_r[`ISA_CTRL_REL] && !clr_rel) begin
                    sh_r <= tx_byte_r;
                    sda_oe <= ~tx_byte_r[7];
                    scl_oe <= 1'b0;
                    cnt_r <= 4'h0;
                    state_r <= S_SEND;
                end
            end
            S_SEND: begin
                if (scl_fall) begin
                    // new bit only while the clock is low
                    if (cnt_r == `ISA_BYTE_BITS - 4'h1) begin
                        sda_oe <= 1'b0;
                        state_r <= S_MACK;
                    end else begin
                        sda_oe <= ~sh_r[6];
                        sh_r <= {sh_r[6:0], 1'b0};
                    end
                    cnt_r <= cnt_r + 4'h1;
                end
            end
            S_MACK: begin
                if (scl_rise)
                    mack_r <= ~sda_lvl;
                if (scl_fall) begin
                    slave_event_flag <= 1'b1;
                    if (mack_r) begin
                        state_r <= S_STRETCH;
                        scl_oe <= 1'b1;
                        clr_rel <= 1'b1;
                    end else begin
                        state_r <= S_IDLE;
                    end
                end
            end
            default: begin
                state_r <= S_IDLE;
            end
        endcase
    end
end

endmodule

// ---- shared/isa_map.vh ----
// register offsets, field positions and reset values of the two-wire slave
// assumes a 32-bit axi4-lite register bus with one word per register
`ifndef ISA_MAP_VH
`define ISA_MAP_VH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define ISA_OFF_CTRL 8'h00
`define ISA_OFF_STAT 8'h04
`define ISA_OFF_RXBUF 8'h08
`define ISA_OFF_TXBYTE 8'h0c
`define ISA_OFF_OWNADDR 8'h10
`define ISA_OFF_BAUD 8'h14

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define ISA_CTRL_EN 15
`define ISA_CTRL_REL 12
`define ISA_CTRL_A10 10
`define ISA_CTRL_RST 16'h1000

// ------------------------------------------------------------------
// status register fields, bits 5:0 read-only
// ------------------------------------------------------------------
`define ISA_STAT_RBF 0
`define ISA_STAT_TBF 1
`define ISA_STAT_RW 2
`define ISA_STAT_FULL_TEN_BIT_MATCH_FLAG 3
`define ISA_STAT_BUSY 4
`define ISA_STAT_OV 6
`define ISA_STAT_RO_W 6
`define ISA_STAT_RST 10'h000

// ------------------------------------------------------------------
// addressing constants and other reset values
// ------------------------------------------------------------------
`define ISA_HDR10 5'h1e
`define ISA_OWN_RST 10'h000
`define ISA_BAUD_RST 9'h000
`define ISA_BYTE_BITS 4'h8

`endif

// ---- verilog/isa_sync.v ----
// two-flop synchroniser with edge detection for one bus line
// assumes the line idles high and comes from outside the core_clk domain
module isa_sync (
    input wire core_clk,
    input wire rst,
    input wire pin_in,
    output wire level,
    output wire rise,
    output wire fall
);

// ------------------------------------------------------------------
// synchroniser; first flop feeds only the second
// ------------------------------------------------------------------
reg meta_r;
reg sync_r;
reg prev_r;

always @(posedge core_clk) begin
    if (rst) begin
        meta_r <= 1'b1;
        sync_r <= 1'b1;
        prev_r <= 1'b1;
    end else begin
        meta_r <= pin_in;
        sync_r <= meta_r;
        prev_r <= sync_r;
    end
end

// edges compare settled copies only
assign level = sync_r;
assign rise = sync_r & ~prev_r;
assign fall = ~sync_r & prev_r;

endmodule

// ---- verilog/isa_axil.v ----
// axi4-lite slave handshake front end for the two-wire slave registers
// assumes the parent decodes addresses combinationally and flags unmapped ones
module isa_axil #(
    parameter AW = 8
) (
    input wire core_clk,
    input wire rst,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire wr_en,
    output reg [AW-1:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_err,
    output wire rd_en,
    output wire [AW-1:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_err
);

// ------------------------------------------------------------------
// write path: address and data taken in either order
// ------------------------------------------------------------------
reg aw_full_r;
reg w_full_r;

assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
assign s_axi_wready = ~w_full_r & ~s_axi_bvalid;
assign wr_en = aw_full_r & w_full_r & ~s_axi_bvalid;

// hold each half until the other arrives, then answer
always @(posedge core_clk) begin
    if (rst) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        wr_addr <= {AW{1'b0}};
        wr_data <= 32'h00000000;
        wr_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        if (wr_en) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? 2'h2 : 2'h0;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ------------------------------------------------------------------
// read path: data sampled in the cycle the address is taken
// ------------------------------------------------------------------
assign s_axi_arready = ~s_axi_rvalid;
assign rd_en = s_axi_arvalid & s_axi_arready;
assign rd_addr = s_axi_araddr;

always @(posedge core_clk) begin
    if (rst) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h0;
    end else if (rd_en) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule

// ---- verif/isa_checker.sv ----
// concurrent checks on the two-wire slave top ports
// assumes one core_clk domain with synchronous active-high rst
module isa_checker (
    input wire core_clk,
    input wire rst,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire scl_out,
    input wire sda_out,
    input wire scl_oe,
    input wire scl_in,
    input wire sda_oe,
    input wire slave_event_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // open drain: a high level would fight the pull-ups and other parties
    drive_low_a: assert property (!scl_out && !sda_out)
        else $error("bus line driven high");
    // slave moves data only after the clock was low, never inside a high phase
    data_low_a: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("data changed with clock high");
    event_pulse_a: assert property (slave_event_flag |=> !slave_event_flag)
        else $error("event pulse too wide");
    // software needs a whole bus write to release, so a stretch never ends at once
    stretch_hold_a: assert property ($rose(scl_oe) |=> scl_oe [*2])
        else $error("stretch released early");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    rst_idle_a: assert property (disable iff (1'b0) rst |=> !scl_oe && !slave_event_flag)
        else $error("bus active after reset");
    cover property (slave_event_flag);
    cover property ($rose(scl_oe));
    cover property (s_axi_rvalid && s_axi_rdata == 32'h0000_00a7);
endmodule
bind isa_top isa_checker chk_u (.*);

// ---- verif/isa_master.sv ----
// behavioural bus master on the clock and data lines
// assumes pull-ups; the slave pulls low through its two enables
module isa_master (
    input wire core_clk,
    input wire scl_oe,
    input wire sda_oe,
    output wire scl,
    output wire sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lo_c = 1'b0;
    logic lo_d = 1'b0;
    // wired-and: a released line reads high, clock stands high between frames
    assign scl = !(lo_c || scl_oe);
    assign sda = !(lo_d || sda_oe);
    // start or repeated start, data falls while clock high
    task start();
        lo_d <= 1'b0;
        repeat (2) @(posedge core_clk);
        lo_c <= 1'b0;
        repeat (4) @(posedge core_clk);
        lo_d <= 1'b1;
        repeat (4) @(posedge core_clk);
        lo_c <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
    task stop();
        lo_d <= 1'b1;
        repeat (2) @(posedge core_clk);
        lo_c <= 1'b0;
        repeat (4) @(posedge core_clk);
        lo_d <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    // nine clocks msb first, 160 ns period; a ninth bit of 1 leaves the line to the slave
    task xfer(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--) begin
            lo_d <= !o[k];
            repeat (2) @(posedge core_clk);
            lo_c <= 1'b0;
            @(posedge core_clk);
            while (!scl) @(posedge core_clk);
            repeat (3) @(posedge core_clk);
            i[k] = sda;
            lo_c <= 1'b1;
            repeat (2) @(posedge core_clk);
        end
    endtask
endmodule

// ---- verif/isa_top_tb.sv ----
// self-checking bench for the two-wire slave top
// assumes the master model on the bus lines and axi4-lite register tasks
module isa_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic aw = 1'b0, w = 1'b0, b = 1'b0, ar = 1'b0, r = 1'b0;
    logic [7:0] wa = 8'h00, ra = 8'h00;
    logic [31:0] wd = 32'h0, cv = 32'h9000;
    logic [8:0] got;
    wire awr, wrd, bv, arr, rvl, scl, sda, coe, doe, evt;
    wire [1:0] rr, br;
    wire [31:0] rd;
    int bad_count = 0, checks_done = 0, evs = 0;
    isa_top dut_u (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(wa), .s_axi_awvalid(aw),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_wvalid(w),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(b),
        .s_axi_araddr(ra), .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rvl), .s_axi_rready(r), .scl_in(scl), .scl_out(),
        .scl_oe(coe), .sda_in(sda), .sda_out(), .sda_oe(doe), .slave_event_flag(evt));
    isa_master m_u (.core_clk(core_clk), .scl_oe(coe), .sda_oe(doe), .scl(scl), .sda(sda));
    initial forever #10 core_clk = ~core_clk;
    // event totals per scenario
    always @(posedge core_clk) if (evt === 1'b1) evs <= evs + 1;
    // hang guard, far above the roughly 1400 cycles needed
    initial begin
        repeat (30000) @(posedge core_clk);
        bad_count++;
        finish_test();
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        wa <= a;
        wd <= d;
        {aw, w, b} <= 3'h7;
        do begin
            @(posedge core_clk);
            if (awr) aw <= 1'b0;
            if (wrd) w <= 1'b0;
        end while (!bv);
        chk("write resp", {30'h0, a > 8'h14, 1'b0}, {30'h0, br});
        b <= 1'b0;
        @(posedge core_clk);
    endtask
    // response code lands in the top two bits of the compared word
    task rreg(input logic [7:0] a, input logic [31:0] e);
        ra <= a;
        {ar, r} <= 2'h3;
        do begin
            @(posedge core_clk);
            if (arr) ar <= 1'b0;
        end while (!rvl);
        chk("register", e, {rr, rd[29:0]});
        r <= 1'b0;
        @(posedge core_clk);
    endtask
    task bx(input logic [8:0] o, input logic [8:0] e);
        m_u.xfer(o, got);
        chk("bus byte", {23'h0, e}, {23'h0, got});
    endtask
    task send(input logic [7:0] v);
        repeat (8) @(posedge core_clk);
        chk("stretch", 32'h1, {31'h0, coe});
        wreg(8'h0c, {24'h0, v});
        wreg(8'h00, cv);
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task t_regs();
        rreg(8'h00, 32'h1000);
        wreg(8'h04, 32'hff);
        rreg(8'h04, 32'hc0);
        wreg(8'h04, 32'h0);
        rreg(8'h20, 32'h8000_0000);
        wreg(8'h20, 32'h0);
        wreg(8'h10, 32'h55);
        wreg(8'h00, cv);
    endtask
    task t_rx();
        evs = 0;
        m_u.start();
        bx(9'h155, 9'h154);
        rreg(8'h08, 32'h0);
        rreg(8'h04, 32'h10);
        bx(9'h14f, 9'h14e);
        bx(9'h079, 9'h079);
        rreg(8'h08, 32'ha7);
        bx(9'h0b5, 9'h0b5);
        m_u.stop();
        rreg(8'h08, 32'h5a);
        chk("rx events", 32'h4, evs);
        wreg(8'h04, 32'h0);
    endtask
    task t_miss();
        logic [6:0] l [4] = '{7'h00, 7'h05, 7'h7c, 7'h56};
        evs = 0;
        foreach (l[k]) begin
            m_u.start();
            bx({l[k], 2'h1}, {l[k], 2'h1});
            m_u.stop();
        end
        chk("miss events", 32'h0, evs);
    endtask
    task t_tx();
        evs = 0;
        m_u.start();
        bx(9'h157, 9'h156);
        send(8'hc3);
        bx(9'h1fe, 9'h186);
        send(8'h81);
        bx(9'h1ff, 9'h103);
        m_u.stop();
        chk("tx events", 32'h3, evs);
    endtask
    task t_ten();
        cv = 32'h9400;
        wreg(8'h10, 32'h2a5);
        wreg(8'h00, cv);
        evs = 0;
        m_u.start();
        bx(9'h1e9, 9'h1e8);
        bx(9'h14b, 9'h14a);
        rreg(8'h04, 32'h18);
        m_u.start();
        bx(9'h1eb, 9'h1ea);
        send(8'h66);
        bx(9'h1ff, 9'h0cd);
        m_u.stop();
        chk("ten events", 32'h4, evs);
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_rx();
        t_miss();
        t_tx();
        t_ten();
        finish_test();
    end
endmodule
